// *** rtl/omsc_consts.svh ***
// Register offsets, field positions, reset values and timing counts for mode and system control
`ifndef OMSC_CONSTS_SVH
`define OMSC_CONSTS_SVH

// Printed offsets are not multiples of four: they are indices, byte address = 4 * index
`define OMSC_IDX_MODE_READOUT   16'hfff1
`define OMSC_IDX_SYS_CONTROL    16'hfff2
`define OMSC_IDX_BUS_CONTROL    16'hfff3

`define OMSC_SC_DEEP_STBY       7
`define OMSC_SC_WAIT_HI         6
`define OMSC_SC_WAIT_LO         4
`define OMSC_SC_USER_EN         3
`define OMSC_SC_NMI_EDGE        2
`define OMSC_SC_FIXED_ONE       1
`define OMSC_SC_RAM_EN          0

`define OMSC_SC_RESET           8'h0b
`define OMSC_SC_WRITE_MASK      8'hfd
`define OMSC_MR_FIXED           8'hc0

// Bus control register: bit 0 = sleep request, bit 1 = wake request, bit 2 = trap entry,
// bits 15:8 = per-area width (1 = 16 bit)
`define OMSC_BC_SLEEP           0
`define OMSC_BC_WAKE            1
`define OMSC_BC_TRAP            2

`define OMSC_WAIT_8192          18'd8192
`define OMSC_WAIT_16384         18'd16384
`define OMSC_WAIT_32768         18'd32768
`define OMSC_WAIT_65536         18'd65536
`define OMSC_WAIT_131072        18'd131072
`define OMSC_WAIT_1024          18'd1024

`endif

// *** rtl/omsc_pkg.sv ***
// Types for mode and system control
package omsc_pkg;
  typedef enum logic [1:0] {
    omsc_run_type_run   = 2'b00,
    omsc_run_type_sleep = 2'b01,
    omsc_run_type_stby  = 2'b10,
    omsc_run_type_wake  = 2'b11
  } omsc_run_type;
endpackage : omsc_pkg

// *** rtl/omsc_top.sv ***
// Operating mode decode and system control register bank on APB
// Mode readout reads are answered from the live synchronised straps, so the
// readout shows the pin levels from at least four clock edges before the setup edge.
// The bus control word is a local addition: sleep, wake and exception
// entry requests, plus the per-area width bits.
`timescale 1ns/100ps
`include "omsc_consts.svh"

module omsc_top
  import omsc_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode strap pins
  input  wire logic        mode_pin_2,
  input  wire logic        mode_pin_1,
  input  wire logic        mode_pin_0,
  // Mode decode
  output logic      [2:0]  mode_num,
  output logic             mode_valid,
  output logic             rom_enable,
  output logic             ext_bus_enable,
  output logic             addr_space_16m,
  output logic             addr_ports_active,
  output logic             bus_16bit,
  output logic             ram_select,
  // System control
  output logic             deep_standby_select,
  output logic      [2:0]  standby_wait_sel,
  output logic             user_flag_enable,
  output logic             nonmask_edge_pick,
  output logic             ram_enable,
  output logic             sleep_active,
  output logic             standby_active,
  output logic             wake_done,
  output logic             flag_mask_set,
  output logic             flag_user_set
);

  initial begin
    if (ADDR_W < 18) begin
      $error("omsc_top: ADDR_W must be at least 18");
    end
  end

  logic [2:0]        sync1;
  logic [2:0]        sync2;
  logic [2:0]        sync3;
  logic [2:0]        strap;
  logic [7:0]        sys_control;
  logic [7:0]        area_width_config;
  logic [ADDR_W-1:0] wait_cnt;
  omsc_run_type      run_state;
  logic              acc;
  logic              wr;
  logic              rd;
  logic [15:0]       idx;
  logic              hit_mr;
  logic              hit_sc;
  logic              hit_bc;
  logic              setup;
  logic              bc_write;
  logic              trap_write;

  // Aligned word whose index matches; byte address = 4 * index
  function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] index);
    reg_hit = (addr[1:0] == 2'b00) && (addr[17:2] == index);
  endfunction : reg_hit

  // Modes with on-chip ROM reachable
  function automatic logic mode_rom_ok(input logic [2:0] m);
    mode_rom_ok = (m == 3'd5) || (m == 3'd6) || (m == 3'd7);
  endfunction : mode_rom_ok

  // Modes with an external bus
  function automatic logic mode_has_ext(input logic [2:0] m);
    mode_has_ext = (m != 3'd0) && (m != 3'd7);
  endfunction : mode_has_ext

  // Modes with the large address space
  function automatic logic mode_big_space(input logic [2:0] m);
    mode_big_space = (m == 3'd3) || (m == 3'd4) || (m == 3'd6);
  endfunction : mode_big_space

  // Modes that start with a wide external bus
  function automatic logic mode_wide_start(input logic [2:0] m);
    mode_wide_start = (m == 3'd2) || (m == 3'd4);
  endfunction : mode_wide_start

  // Readout word: fixed high bits over the pin levels
  function automatic logic [7:0] readout_word(input logic [2:0] m);
    readout_word = `OMSC_MR_FIXED | {5'b0_0000, m};
  endfunction : readout_word

  assign idx        = paddr[17:2];
  assign acc        = psel & penable;
  assign setup      = psel & ~penable;
  assign wr         = acc & pwrite;
  assign rd         = acc & ~pwrite;
  assign hit_mr     = reg_hit(paddr, `OMSC_IDX_MODE_READOUT);
  assign hit_sc     = reg_hit(paddr, `OMSC_IDX_SYS_CONTROL);
  assign hit_bc     = reg_hit(paddr, `OMSC_IDX_BUS_CONTROL);
  assign bc_write   = wr & hit_bc & pstrb[0];
  assign trap_write = bc_write & pwdata[`OMSC_BC_TRAP];

  function automatic logic [ADDR_W-1:0] wait_states(input logic [2:0] sel);
    case (sel)
      3'b000:  wait_states = ADDR_W'(`OMSC_WAIT_8192);
      3'b001:  wait_states = ADDR_W'(`OMSC_WAIT_16384);
      3'b010:  wait_states = ADDR_W'(`OMSC_WAIT_32768);
      3'b011:  wait_states = ADDR_W'(`OMSC_WAIT_65536);
      3'b100:  wait_states = ADDR_W'(`OMSC_WAIT_131072);
      3'b101:  wait_states = ADDR_W'(`OMSC_WAIT_1024);
      default: wait_states = ADDR_W'(`OMSC_WAIT_131072); // Illegal codes: longest wait
    endcase
  endfunction : wait_states

  // Strap synchroniser chain
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1 <= 3'b000;
      sync2 <= 3'b000;
      sync3 <= 3'b000;
    end else begin
      sync1 <= {mode_pin_2, mode_pin_1, mode_pin_0};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Change accepted once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      strap <= 3'b000;
    end else if (sync2 == sync3) begin
      strap <= sync3;
    end
  end

  // Mode number and validity
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_num   <= 3'b000;
      mode_valid <= 1'b0;
    end else begin
      mode_num   <= strap;
      mode_valid <= (strap != 3'b000);
    end
  end

  // Memory map properties of the mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rom_enable        <= 1'b0;
      ext_bus_enable    <= 1'b0;
      addr_space_16m    <= 1'b0;
      addr_ports_active <= 1'b0;
    end else begin
      rom_enable        <= mode_rom_ok(strap);
      ext_bus_enable    <= mode_has_ext(strap);
      addr_space_16m    <= mode_big_space(strap);
      addr_ports_active <= (strap >= 3'd1) && (strap <= 3'd4);
    end
  end

  // Area width config: mode default until the mode settles, then software
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      area_width_config <= 8'h00;
    end else if (run_state == omsc_run_type_run && !mode_valid) begin
      area_width_config <= mode_wide_start(strap) ? 8'hff : 8'h00;
    end else if (wr && hit_bc && pstrb[1]) begin
      area_width_config <= pwdata[15:8];
    end
  end

  // Any wide area makes the external bus 16 bit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_16bit <= 1'b0;
    end else begin
      bus_16bit <= ext_bus_enable && (area_width_config != 8'h00);
    end
  end

  // System control register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sys_control <= `OMSC_SC_RESET;
    end else if (wr && hit_sc && pstrb[0]) begin
      // Bit 1 stays one; writes to it are dropped
      sys_control <= (pwdata[7:0] & `OMSC_SC_WRITE_MASK) | 8'h02;
    end
  end

  // Power-down sequencing: sleep target, standby, wake settling wait
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      run_state <= omsc_run_type_run;
      wait_cnt  <= '0;
      wake_done <= 1'b0;
    end else begin
      wake_done <= 1'b0;
      case (run_state)
        omsc_run_type_run: begin
          if (bc_write && pwdata[`OMSC_BC_SLEEP]) begin
            run_state <= sys_control[`OMSC_SC_DEEP_STBY] ? omsc_run_type_stby
                                                          : omsc_run_type_sleep;
          end
        end
        omsc_run_type_sleep: begin
          if (bc_write && pwdata[`OMSC_BC_WAKE]) begin
            run_state <= omsc_run_type_run;
            wake_done <= 1'b1;
          end
        end
        omsc_run_type_stby: begin
          if (bc_write && pwdata[`OMSC_BC_WAKE]) begin
            wait_cnt  <= wait_states(sys_control[6:4]);
            run_state <= omsc_run_type_wake;
          end
        end
        omsc_run_type_wake: begin
          if (wait_cnt <= ADDR_W'(1)) begin
            run_state <= omsc_run_type_run;
            wake_done <= 1'b1;
          end else begin
            wait_cnt <= wait_cnt - ADDR_W'(1);
          end
        end
        default: run_state <= omsc_run_type_run;
      endcase
    end
  end

  // Control field copies, one cycle behind the register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      deep_standby_select <= 1'b0;
      standby_wait_sel    <= 3'b000;
      user_flag_enable    <= 1'b1;
      nonmask_edge_pick   <= 1'b0;
      ram_enable          <= 1'b1;
    end else begin
      deep_standby_select <= sys_control[`OMSC_SC_DEEP_STBY];
      standby_wait_sel    <= sys_control[`OMSC_SC_WAIT_HI:`OMSC_SC_WAIT_LO];
      user_flag_enable    <= sys_control[`OMSC_SC_USER_EN];
      nonmask_edge_pick   <= sys_control[`OMSC_SC_NMI_EDGE];
      ram_enable          <= sys_control[`OMSC_SC_RAM_EN];
    end
  end

  // On-chip RAM routing; single-chip mode never goes external
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ram_select <= 1'b0;
    end else begin
      ram_select <= sys_control[`OMSC_SC_RAM_EN] || (strap == 3'd7);
    end
  end

  // Power state levels
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sleep_active   <= 1'b0;
      standby_active <= 1'b0;
    end else begin
      sleep_active   <= (run_state == omsc_run_type_sleep);
      standby_active <= (run_state == omsc_run_type_stby) ||
                        (run_state == omsc_run_type_wake);
    end
  end

  // Exception entry strobes; user flag only when it serves as a mask
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_mask_set <= 1'b0;
      flag_user_set <= 1'b0;
    end else begin
      flag_mask_set <= trap_write;
      flag_user_set <= trap_write && !sys_control[`OMSC_SC_USER_EN];
    end
  end

  // APB handshake: ready in the access cycle right after setup
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !(hit_mr || hit_sc || hit_bc);
    end
  end

  // APB read data, prepared at the setup edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= 32'h0000_0000;
      if (setup && !pwrite) begin
        if (hit_mr) begin
          prdata <= {24'h00_0000, readout_word(strap)};
        end else if (hit_sc) begin
          prdata <= {24'h00_0000, sys_control};
        end else if (hit_bc) begin
          prdata <= {16'h0000, area_width_config, 5'b0_0000,
                     (run_state == omsc_run_type_wake), standby_active, sleep_active};
        end
      end
    end
  end

endmodule : omsc_top

// *** test/omsc_checker_assertions.sv ***
// Concurrent checks on the mode decode and system control ports
`timescale 1ns/100ps
module omsc_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Decode and control
  input wire logic [2:0]  mode_num,
  input wire logic        mode_valid,
  input wire logic        rom_enable,
  input wire logic        ext_bus_enable,
  input wire logic        addr_space_16m,
  input wire logic        bus_16bit,
  input wire logic        ram_select,
  input wire logic        ram_enable,
  input wire logic        user_flag_enable,
  input wire logic        flag_mask_set,
  input wire logic        flag_user_set
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence sc_rd;
    psel && penable && pready && !pwrite && paddr == 32'h0003_ffc8;
  endsequence
  sequence mr_rd;
    psel && penable && pready && !pwrite && paddr == 32'h0003_ffc4;
  endsequence
  chk_rom_access: assert property (mode_valid |-> rom_enable == (mode_num >= 3'd5))
    else $error("rom enable wrong for mode");
  chk_space_size: assert property (mode_valid |-> addr_space_16m == (mode_num inside {3, 4, 6}))
    else $error("address space size wrong for mode");
  chk_ext_bus: assert property (mode_valid |-> ext_bus_enable == (mode_num != 3'd7))
    else $error("external bus enable wrong for mode");
  chk_width_none: assert property (mode_num == 3'd7 |-> !bus_16bit)
    else $error("wide bus in single chip mode");
  chk_ram_route: assert property ((mode_valid && mode_num != 3'd7 && !ram_enable) [*2] |-> !ram_select)
    else $error("ram still selected while disabled");
  chk_fixed_one: assert property (sc_rd |-> prdata[1] && prdata[31:8] == 24'h00_0000)
    else $error("control bit 1 not read as one");
  chk_mode_fixed: assert property (mr_rd |-> prdata[7:3] == 5'b11000)
    else $error("mode readout fixed bits wrong");
  chk_reset_value: assert property ($fell(srst) |-> user_flag_enable && ram_enable)
    else $error("control reset value wrong");
  chk_user_flag: assert property (flag_user_set |-> flag_mask_set && !$past(user_flag_enable))
    else $error("user flag set without mask or enable");
endmodule : omsc_checker

bind omsc_top omsc_checker chk_inst (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .mode_num, .mode_valid, .rom_enable, .ext_bus_enable, .addr_space_16m,
  .bus_16bit, .ram_select, .ram_enable, .user_flag_enable, .flag_mask_set, .flag_user_set);

// *** test/omsc_strap_model.sv ***
// Board strap model: holds the three mode pins at a chosen valid pattern
`timescale 1ns/100ps
module omsc_strap_model (
  // Chosen pattern
  input  wire logic [2:0] mode,
  // Strap pins
  output logic            mode_pin_2,
  output logic            mode_pin_1,
  output logic            mode_pin_0
);
  // Bench changes the pattern only while reset is held
  assign {mode_pin_2, mode_pin_1, mode_pin_0} = mode;
endmodule : omsc_strap_model

// *** test/test_operating_mode_and_system_control.sv ***
// Self-checking bench for mode decode and system control
`timescale 1ns/100ps
module test_operating_mode_and_system_control;
  logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd, d, seed;
  logic [3:0]  pstrb;
  logic [2:0]  mode, mode_num, standby_wait_sel;
  logic        mode_pin_2, mode_pin_1, mode_pin_0, mode_valid, rom_enable, ext_bus_enable;
  logic        addr_space_16m, addr_ports_active, bus_16bit, ram_select, deep_standby_select;
  logic        user_flag_enable, nonmask_edge_pick, ram_enable, sleep_active, standby_active;
  logic        wake_done, flag_mask_set, flag_user_set;
  logic [7:0]  sc_m;
  int          errors, check_count, cyc, n;
  localparam logic [31:0] MR_A = 32'h0003_ffc4;
  localparam logic [31:0] SC_A = 32'h0003_ffc8;
  localparam logic [31:0] BC_A = 32'h0003_ffcc;

  omsc_strap_model strap_inst (.mode, .mode_pin_2, .mode_pin_1, .mode_pin_0);
  omsc_top omsc_top_inst (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .mode_pin_2, .mode_pin_1, .mode_pin_0, .mode_num, .mode_valid,
    .rom_enable, .ext_bus_enable, .addr_space_16m, .addr_ports_active, .bus_16bit, .ram_select,
    .deep_standby_select, .standby_wait_sel, .user_flag_enable, .nonmask_edge_pick, .ram_enable,
    .sleep_active, .standby_active, .wake_done, .flag_mask_set, .flag_user_set);

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  task finish_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  task cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp

  function logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task apb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r,
           output logic e);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task do_reset;
    srst <= 1;
    repeat (20) @(posedge clk_sys);
    srst <= 0;
    repeat (8) @(posedge clk_sys);
  endtask : do_reset

  // k = 0 waits for the user flag pulse, k = 1 for the wake pulse
  task wait_pulse(input int k);
    n = 0;
    while (n < 2000 && !((k == 0) ? flag_user_set === 1'b1 : wake_done === 1'b1)) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_pulse

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    srst = 1;
    mode = 3'd1;
    seed = 32'hb724_d387;
    for (int m = 1; m <= 7; m++) begin
      mode <= m[2:0];
      do_reset();
      cmp({mode_num, rom_enable, ext_bus_enable, addr_space_16m, bus_16bit},
          {m[2:0], m >= 5, m < 7, m == 3 || m == 4 || m == 6, m == 2 || m == 4});
      if (m < 3) cmp(addr_ports_active, 1);
      apb(1, MR_A, 32'h0000_0000, rd, er);
      apb(0, MR_A, 32'h0000_0000, rd, er);
      cmp(rd, 32'h0000_00c0 | m);
    end
    mode <= 3'd1;
    do_reset();
    apb(0, SC_A, 32'h0000_0000, rd, er);
    cmp(rd, 32'h0000_000b);
    repeat (4) begin
      d = rnd();
      apb(1, SC_A, d, rd, er);
      sc_m = (d[7:0] & 8'hfd) | 8'h02;
      apb(0, SC_A, 32'h0000_0000, rd, er);
      cmp(rd, sc_m);
      cmp({deep_standby_select, standby_wait_sel, user_flag_enable, nonmask_edge_pick,
           ram_enable}, {sc_m[7:2], sc_m[0]});
    end
    apb(1, SC_A, 32'h0000_000a, rd, er);
    repeat (2) @(posedge clk_sys);
    cmp(ram_select, 0);
    for (int a = 1; a >= 0; a--) begin
      apb(1, BC_A, 32'h0000_0400 * a, rd, er);
      repeat (2) @(posedge clk_sys);
      cmp(bus_16bit, a);
    end
    apb(1, SC_A, 32'h0000_0051, rd, er);
    apb(1, BC_A, 32'h0000_0004, rd, er);
    wait_pulse(0);
    cmp(n < 10, 1);
    apb(1, SC_A, 32'h0000_00d1, rd, er);
    apb(1, BC_A, 32'h0000_0001, rd, er);
    repeat (3) @(posedge clk_sys);
    cmp({sleep_active, standby_active}, 2'b01);
    apb(1, BC_A, 32'h0000_0002, rd, er);
    wait_pulse(1);
    cmp(n >= 1024 && n < 1040, 1);
    cmp({deep_standby_select, ram_enable}, 2'b11);
    apb(1, SC_A, 32'h0000_0051, rd, er);
    apb(1, BC_A, 32'h0000_0001, rd, er);
    repeat (3) @(posedge clk_sys);
    cmp({sleep_active, standby_active}, 2'b10);
    apb(0, 32'h0000_0010, 32'h0000_0000, rd, er);
    cmp({er, rd[7:0]}, 9'h100);
    finish_test();
  end
endmodule : test_operating_mode_and_system_control
